// File: rtl/refc_pkg.sv
// Purpose: Shared constants for the right-channel effects filter coefficient bank
// Assumes: AXI4-Lite, 32-bit data, one byte register per aligned word
// Notes:   Register indices are byte-wide; the bus address is four times the index
package refc_pkg;

    // Register indices, bus address is index * 4
    localparam logic [7:0] IDX_NUM_FOUR_HIGH = 8'h23;
    localparam logic [7:0] IDX_NUM_FOUR_LOW  = 8'h24;
    localparam logic [7:0] IDX_NUM_FIVE_HIGH = 8'h25;
    localparam logic [7:0] IDX_NUM_FIVE_LOW  = 8'h26;
    localparam logic [7:0] IDX_DEN_ONE_HIGH  = 8'h27;
    localparam logic [7:0] IDX_DEN_ONE_LOW   = 8'h28;
    localparam logic [7:0] IDX_DEN_TWO_HIGH  = 8'h29;
    localparam logic [7:0] IDX_DEN_TWO_LOW   = 8'h2A;

    // Bank geometry
    localparam int          NUM_REGS   = 8;
    localparam int          SLOT_W     = 3;
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 32;
    localparam int          BYTE_W     = 8;
    localparam int          COEF_W     = 16;
    localparam logic [1:0]  ALIGN_BITS = 2'h0;

    // Reset values
    localparam logic [7:0] RST_NUM_FOUR_HIGH = 8'h96;
    localparam logic [7:0] RST_NUM_FOUR_LOW  = 8'h66;
    localparam logic [7:0] RST_NUM_FIVE_HIGH = 8'h67;
    localparam logic [7:0] RST_NUM_FIVE_LOW  = 8'h5D;
    localparam logic [7:0] RST_DEN_ONE_HIGH  = 8'h7D;
    localparam logic [7:0] RST_DEN_ONE_LOW   = 8'h83;
    localparam logic [7:0] RST_DEN_TWO_HIGH  = 8'h84;
    localparam logic [7:0] RST_DEN_TWO_LOW   = 8'hEE;

    // Response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage // refc_pkg

// File: rtl/refc_coef_pair.sv
// Purpose: Join one coefficient's upper and lower byte into a signed word
// Assumes: Bytes come straight from the register bank flops
// Notes:   One cycle of latency from register to coefficient output
`timescale 1ns/1ns
module refc_coef_pair (
    // Clock and reset
    input  wire logic                                 aclk,
    input  wire logic                                 aresetn,
    // Byte inputs
    input  wire logic [refc_pkg::BYTE_W-1:0]          high_byte,
    input  wire logic [refc_pkg::BYTE_W-1:0]          low_byte,
    input  wire logic [refc_pkg::COEF_W-1:0]          rst_word,
    // Coefficient out
    output logic signed [refc_pkg::COEF_W-1:0]        coef_q
);

    // Register the joined word so the datapath sees a clean flop
    // Reset loads the reset word, so no zero coefficient leaks out after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            coef_q <= $signed(rst_word);
        end else begin
            coef_q <= $signed({high_byte, low_byte});
        end
    end

endmodule // refc_coef_pair

// File: rtl/refc_bank.sv
// Purpose: Right-channel effects filter coefficient registers on AXI4-Lite
// Assumes: Single clock aclk at 250 MHz, synchronous active-low reset
// Notes:   Eight byte registers, four signed 16-bit coefficients out
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
module refc_bank (
    // Clock and reset
    input  wire logic                                   aclk,
    input  wire logic                                   aresetn,
    // AXI4-Lite write address
    input  wire logic                                   s_axi_awvalid,
    output logic                                        s_axi_awready,
    input  wire logic [refc_pkg::ADDR_W-1:0]            s_axi_awaddr,
    input  wire logic [2:0]                             s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic                                   s_axi_wvalid,
    output logic                                        s_axi_wready,
    input  wire logic [refc_pkg::DATA_W-1:0]            s_axi_wdata,
    input  wire logic [3:0]                             s_axi_wstrb,
    // AXI4-Lite write response
    output logic                                        s_axi_bvalid,
    input  wire logic                                   s_axi_bready,
    output logic [1:0]                                  s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                                   s_axi_arvalid,
    output logic                                        s_axi_arready,
    input  wire logic [refc_pkg::ADDR_W-1:0]            s_axi_araddr,
    input  wire logic [2:0]                             s_axi_arprot,
    // AXI4-Lite read data
    output logic                                        s_axi_rvalid,
    input  wire logic                                   s_axi_rready,
    output logic [refc_pkg::DATA_W-1:0]                 s_axi_rdata,
    output logic [1:0]                                  s_axi_rresp,
    // Coefficients to filter datapath
    output logic signed [refc_pkg::COEF_W-1:0]          numerator_coeff_four,
    output logic signed [refc_pkg::COEF_W-1:0]          numerator_coeff_five,
    output logic signed [refc_pkg::COEF_W-1:0]          denominator_coeff_one,
    output logic signed [refc_pkg::COEF_W-1:0]          denominator_coeff_two
);

    // Decode: hit flag and slot from a byte address
    function automatic logic [refc_pkg::SLOT_W:0] decode(
        input logic [refc_pkg::ADDR_W-1:0] addr
    );
        logic [refc_pkg::ADDR_W-1:0] idx;
        logic [refc_pkg::ADDR_W-1:0] off;
        idx = {2'h0, addr[refc_pkg::ADDR_W-1:2]};
        off = idx - refc_pkg::IDX_NUM_FOUR_HIGH;
        decode = {(addr[1:0] == refc_pkg::ALIGN_BITS)
                  && (idx >= refc_pkg::IDX_NUM_FOUR_HIGH)
                  && (idx <= refc_pkg::IDX_DEN_TWO_LOW),
                  off[refc_pkg::SLOT_W-1:0]};
    endfunction

    // Slot map, byte address = index * 4:
    //   slot 0  0x8C  numerator four, upper byte
    //   slot 1  0x90  numerator four, lower byte
    //   slot 2  0x94  numerator five, upper byte
    //   slot 3  0x98  numerator five, lower byte
    //   slot 4  0x9C  denominator one, upper byte
    //   slot 5  0xA0  denominator one, lower byte
    //   slot 6  0xA4  denominator two, upper byte
    //   slot 7  0xA8  denominator two, lower byte
    // Anything else, or an address with low bits set, answers an error

    // Byte storage, slot 0 is numerator four upper byte
    logic [refc_pkg::BYTE_W-1:0]  regs_q [refc_pkg::NUM_REGS];

    // Write and read channel holding state
    logic                             aw_held_q;
    logic                             w_held_q;
    logic [refc_pkg::ADDR_W-1:0]      awaddr_q;
    logic [refc_pkg::BYTE_W-1:0]      wbyte_q;
    logic                             wlane_q;
    logic                             bvalid_q;
    logic [1:0]                       bresp_q;
    logic                             rvalid_q;
    logic [refc_pkg::DATA_W-1:0]      rdata_q;
    logic [1:0]                       rresp_q;
    logic                             wr_go;
    logic [refc_pkg::SLOT_W:0]        wr_dec;
    logic [refc_pkg::SLOT_W:0]        rd_dec;
    logic                             unused_prot;

    // Handshake readies; one write and one read in flight at most
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign unused_prot   = ^{s_axi_awprot, s_axi_arprot, s_axi_wstrb[3:1],
                             s_axi_wdata[refc_pkg::DATA_W-1:refc_pkg::BYTE_W]};

    // Commit once both address and data are held
    // Gating on bvalid keeps a second store out until the answer retires
    assign wr_go  = aw_held_q && w_held_q && !bvalid_q;
    assign wr_dec = decode(awaddr_q);
    assign rd_dec = decode(s_axi_araddr);

    // Capture write address, order-free against write data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
        end
    end

    // Capture write data; only lane 0 carries a register byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wbyte_q  <= '0;
            wlane_q  <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wbyte_q  <= s_axi_wdata[refc_pkg::BYTE_W-1:0];
            wlane_q  <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_held_q <= 1'b0;
        end
    end

    // Register bank with documented reset values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            regs_q[0] <= refc_pkg::RST_NUM_FOUR_HIGH;
            regs_q[1] <= refc_pkg::RST_NUM_FOUR_LOW;
            regs_q[2] <= refc_pkg::RST_NUM_FIVE_HIGH;
            regs_q[3] <= refc_pkg::RST_NUM_FIVE_LOW;
            regs_q[4] <= refc_pkg::RST_DEN_ONE_HIGH;
            regs_q[5] <= refc_pkg::RST_DEN_ONE_LOW;
            regs_q[6] <= refc_pkg::RST_DEN_TWO_HIGH;
            regs_q[7] <= refc_pkg::RST_DEN_TWO_LOW;
        end else if (wr_go && wr_dec[refc_pkg::SLOT_W] && wlane_q) begin
            regs_q[wr_dec[refc_pkg::SLOT_W-1:0]] <= wbyte_q;
        end
    end

    // Write response; unmapped or misaligned gets SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= refc_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_dec[refc_pkg::SLOT_W] ? refc_pkg::RESP_OKAY
                                                 : refc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read path, one cycle after the address is taken
    // Address decoded straight off the bus, so no read address flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= refc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            if (rd_dec[refc_pkg::SLOT_W]) begin
                rdata_q <= {24'h000000, regs_q[rd_dec[refc_pkg::SLOT_W-1:0]]};
                rresp_q <= refc_pkg::RESP_OKAY;
            end else begin
                rdata_q <= '0;
                rresp_q <= refc_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Coefficient joiners feed the filter datapath
    refc_coef_pair u_num_four (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .high_byte (regs_q[0]),
        .low_byte  (regs_q[1]),
        .rst_word  ({refc_pkg::RST_NUM_FOUR_HIGH, refc_pkg::RST_NUM_FOUR_LOW}),
        .coef_q    (numerator_coeff_four)
    );
    refc_coef_pair u_num_five (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .high_byte (regs_q[2]),
        .low_byte  (regs_q[3]),
        .rst_word  ({refc_pkg::RST_NUM_FIVE_HIGH, refc_pkg::RST_NUM_FIVE_LOW}),
        .coef_q    (numerator_coeff_five)
    );
    refc_coef_pair u_den_one (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .high_byte (regs_q[4]),
        .low_byte  (regs_q[5]),
        .rst_word  ({refc_pkg::RST_DEN_ONE_HIGH, refc_pkg::RST_DEN_ONE_LOW}),
        .coef_q    (denominator_coeff_one)
    );
    refc_coef_pair u_den_two (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .high_byte (regs_q[6]),
        .low_byte  (regs_q[7]),
        .rst_word  ({refc_pkg::RST_DEN_TWO_HIGH, refc_pkg::RST_DEN_TWO_LOW}),
        .coef_q    (denominator_coeff_two)
    );

    // Checks, all in the aclk domain
    // Reset checks look one edge after release, when bytes are
    // guaranteed to hold their reset values and no write has landed
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    num_four_rst_a: assert property ($past(!aresetn) |->
        regs_q[0] == 8'h96 && regs_q[1] == 8'h66)
        else $error("numerator four reset value wrong");
    num_five_rst_a: assert property ($past(!aresetn) |->
        regs_q[2] == 8'h67 && regs_q[3] == 8'h5D)
        else $error("numerator five reset value wrong");
    den_one_rst_a: assert property ($past(!aresetn) |->
        regs_q[4] == 8'h7D && regs_q[5] == 8'h83)
        else $error("denominator one reset value wrong");
    den_two_hi_a: assert property ($past(!aresetn) |-> regs_q[6] == 8'h84)
        else $error("denominator two upper reset wrong");
    den_two_lo_a: assert property ($past(!aresetn) |-> regs_q[7] == 8'hEE)
        else $error("denominator two lower reset wrong");
    coef_join_a: assert property (##1 numerator_coeff_five ==
        $signed({$past(regs_q[2]), $past(regs_q[3])}))
        else $error("coefficient not joined from bytes");
    byte_write_a: assert property (wr_go && wr_dec[refc_pkg::SLOT_W] && wlane_q
        |=> regs_q[$past(wr_dec[refc_pkg::SLOT_W-1:0])] == $past(wbyte_q))
        else $error("written byte not stored");
    read_back_a: assert property (s_axi_arvalid && s_axi_arready
        && rd_dec[refc_pkg::SLOT_W]
        |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(regs_q[rd_dec[2:0]])
            && s_axi_rdata[31:8] == 24'h000000)
        else $error("read data does not match register");
    coef_follow_a: assert property (wr_go && wr_dec == 4'h8 && wlane_q
        |-> ##2 numerator_coeff_four[15:8] == $past(wbyte_q, 2))
        else $error("datapath did not see new coefficient");
    bresp_order_a: assert property (wr_go |=> s_axi_bvalid [*1] ##0
        (s_axi_bresp == (($past(wr_dec) >= 4'h8) ? 2'h0 : 2'h2)))
        else $error("write response wrong");

    // Remaining coefficients follow their byte pairs one clock later
    coef_four_join_a: assert property (##1 numerator_coeff_four ==
        $signed({$past(regs_q[0]), $past(regs_q[1])}))
        else $error("numerator four not joined from bytes");
    coef_one_join_a: assert property (##1 denominator_coeff_one ==
        $signed({$past(regs_q[4]), $past(regs_q[5])}))
        else $error("denominator one not joined from bytes");
    coef_two_join_a: assert property (##1 denominator_coeff_two ==
        $signed({$past(regs_q[6]), $past(regs_q[7])}))
        else $error("denominator two not joined from bytes");

    // Coefficients carry their reset words from the first edge after release
    coef_rst_a: assert property ($past(!aresetn) |->
        numerator_coeff_four == 16'h9666 && numerator_coeff_five == 16'h675D
        && denominator_coeff_one == 16'h7D83 && denominator_coeff_two == 16'h84EE)
        else $error("coefficient reset word wrong");

    // Bus side: refusals, captures and retiring answers
    rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready
        && !rd_dec[refc_pkg::SLOT_W]
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    strobe_skip_a: assert property (wr_go && !wlane_q
        |=> regs_q[$past(wr_dec[refc_pkg::SLOT_W-1:0])]
            == $past(regs_q[wr_dec[refc_pkg::SLOT_W-1:0]]))
        else $error("write without lane 0 changed a byte");
    addr_take_a: assert property (s_axi_awvalid && s_axi_awready
        |=> aw_held_q && awaddr_q == $past(s_axi_awaddr))
        else $error("write address not captured");
    data_take_a: assert property (s_axi_wvalid && s_axi_wready
        |=> w_held_q && wbyte_q == $past(s_axi_wdata[7:0]))
        else $error("write data not captured");
    busy_refuse_a: assert property (wr_go
        |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("new write accepted before answer");
    bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response did not retire");
    rresp_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response did not retire");

    // Main scenarios
    wr_ok_c:  cover property (wr_go && wr_dec[refc_pkg::SLOT_W]);
    wr_bad_c: cover property (wr_go && !wr_dec[refc_pkg::SLOT_W]);
    rd_ok_c:  cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h0);
    rd_bad_c: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h2);
    wr_skip_c: cover property (wr_go && wr_dec[refc_pkg::SLOT_W] && !wlane_q);

endmodule // refc_bank

// File: tb/refc_bank_tb.sv
// Purpose: Self-checking bench for the right-channel coefficient bank
// Assumes: Bench is the AXI4-Lite master; bready and rready held high
// Notes:   Byte address is four times the register index
`timescale 1ns/1ns
module refc_bank_tb;
    // Bus, clock and coefficient signals
    logic               aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic               arvalid, arready, rvalid, rready;
    logic [7:0]         awaddr, araddr;
    logic [2:0]         awprot, arprot;
    logic [31:0]        wdata, rdata;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp;
    logic signed [15:0] coef_num_four, coef_num_five, coef_den_one, coef_den_two;
    // Bench state and expected reset bytes
    int                 fail_count, total_checks, cycles;
    logic [7:0]         mirror [8];
    logic [7:0]         rst_tab [8] = '{8'h96, 8'h66, 8'h67, 8'h5D, 8'h7D, 8'h83, 8'h84, 8'hEE};
    logic [7:0]         bad_tab [4] = '{8'h00, 8'hAC, 8'h8D, 8'h88};

    refc_bank dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_arprot(arprot), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .numerator_coeff_four(coef_num_four),
        .numerator_coeff_five(coef_num_five), .denominator_coeff_one(coef_den_one),
        .denominator_coeff_two(coef_den_two));

    // Free-running 250 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t resp %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] addr_of(input int i);
        return 8'((int'(refc_pkg::IDX_NUM_FOUR_HIGH) + i) * 4);
    endfunction

    // Expected coefficient: upper byte sits at the lower index
    function automatic logic [15:0] exp_coef(input int k);
        return {mirror[2*k], mirror[2*k+1]};
    endfunction

    // Readies sampled at the settled negedge; valids dropped after the taking edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awprot <= 3'($urandom);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = (bvalid === 1'b1);
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        araddr <= a;
        arprot <= 3'($urandom);
        arvalid <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = (rvalid === 1'b1);
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
    endtask

    // Write one byte register with random upper lanes, track it
    task automatic wm(input int i, input logic [7:0] v);
        logic [1:0] r;
        axi_write(addr_of(i), {24'($urandom), v}, {3'($urandom), 1'b1}, r);
        check_resp(r, refc_pkg::RESP_OKAY);
        mirror[i] = v;
    endtask

    task automatic rd_check(input int i);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(addr_of(i), d, r);
        check_data(d, {24'h0, mirror[i]});
        check_resp(r, refc_pkg::RESP_OKAY);
    endtask

    // Coefficients trail the bytes by one clock, so look a half cycle later
    task automatic check_all(input string name);
        for (int i = 0; i < 8; i++) rd_check(i);
        @(negedge aclk);
        check_data({16'h0, coef_num_four}, {16'h0, exp_coef(0)});
        check_data({16'h0, coef_num_five}, {16'h0, exp_coef(1)});
        check_data({16'h0, coef_den_one}, {16'h0, exp_coef(2)});
        check_data({16'h0, coef_den_two}, {16'h0, exp_coef(3)});
        @(posedge aclk);
        $display("test %s done", name);
    endtask

    initial begin : main
        logic [31:0] d;
        logic [1:0]  r;
        {awvalid, wvalid, arvalid, aresetn, fail_count, total_checks, cycles} = '0;
        {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
        bready = 1'b1;
        rready = 1'b1;
        void'($urandom(63));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        mirror = rst_tab;
        check_all("reset values");
        // Sign boundaries of a coefficient
        wm(0, 8'h80);
        wm(1, 8'h00);
        wm(2, 8'h7F);
        wm(3, 8'hFF);
        check_all("sign corners");
        check_data(32'(coef_num_four), 32'hFFFF8000);
        check_data(32'(coef_num_five), 32'h00007FFF);
        for (int i = 0; i < 8; i++) wm(i, 8'hFF);
        check_all("all ones");
        for (int i = 0; i < 8; i++) wm(i, 8'h00);
        check_all("all zeros");
        repeat (40) begin
            wm($urandom % 8, 8'($urandom));
            rd_check($urandom % 8);
        end
        check_all("random traffic");
        // Unmapped and misaligned places store nothing and answer an error
        foreach (bad_tab[j]) begin
            axi_write(bad_tab[j], 32'($urandom), 4'hF, r);
            check_resp(r, refc_pkg::RESP_SLVERR);
            axi_read(bad_tab[j], d, r);
            check_data(d, 32'h0);
            check_resp(r, refc_pkg::RESP_SLVERR);
        end
        axi_write(addr_of(4), 32'h5A, 4'hE, r);
        check_resp(r, refc_pkg::RESP_OKAY);
        check_all("refusals");
        // Reset in mid-run restores every byte
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        mirror = rst_tab;
        check_all("second reset");
        print_verdict();
    end
endmodule // refc_bank_tb
